// ==== pclk_pkg.sv ====
package pclk_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h0d;
  localparam logic [7:0] ADDR_CFG_AB = 8'h0e;
  localparam logic [7:0] ADDR_CFG_C = 8'h0f;
  localparam logic [7:0] ADDR_WIDTH = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_AB_RESET = 16'h0501;
  localparam logic [7:0] CFG_C_RESET = 8'h03;
  localparam logic [11:0] WIDTH_RESET = 12'h640;
  localparam logic [15:0] CFG_AB_MASK = 16'hefff;
  localparam logic [7:0] CFG_C_MASK = 8'hef;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int VAR_EN_BIT = 6;
  localparam int DIV_W = 4;
  localparam int SLEW_W = 3;
  localparam int WIDTH_W = 12;
  localparam int DIV_A_LSB = 0;
  localparam int SLEW_A_LSB = 5;
  localparam int DIV_B_LSB = 8;
  localparam int SLEW_B_LSB = 13;
  localparam int DIV_C_LSB = 0;
  localparam int SLEW_C_LSB = 5;
  localparam logic [3:0] DIV_ONE = 4'h1;

  // ----------------------------------------------------------------
  // output buffer fullness thresholds
  // ----------------------------------------------------------------
  localparam int FILL_W = 11;
  localparam logic [10:0] FIFO_CAP = 11'h400;
  localparam logic [10:0] FILL_QUARTER = FIFO_CAP >> 2;
  localparam logic [10:0] FILL_HALF = FIFO_CAP >> 1;
  localparam logic [10:0] FILL_THREEQ = FILL_HALF + FILL_QUARTER;

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_A = 3'h1,
    SRC_B = 3'h2,
    SRC_C = 3'h4
  } src_t;

endpackage

// ==== div_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface div_if;
  logic [3:0] divisor;
  logic restart;
  logic last;
  logic level_next;
  modport ctrl (output divisor, output restart, input last, input level_next);
  modport gen (input divisor, input restart, output last, output level_next);
endinterface

`default_nettype wire

// ==== pclk_divider.sv ====
`timescale 1ns/1ps
`default_nettype none

module pclk_divider (
  input wire logic clk,
  input wire logic rst_n,
  div_if.gen port
);
  typedef struct packed {
    logic [3:0] cnt;
  } div_state_t;

  div_state_t st;
  div_state_t nx;
  logic [3:0] n_eff;
  logic [3:0] high_len;

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  always_comb begin
    n_eff = (port.divisor == 4'h0) ? pclk_pkg::DIV_ONE : port.divisor;
    high_len = 4'((5'(n_eff) + 5'h01) >> 1);
    // >= so a divisor cut mid-period wraps at once, not after rolling past 15
    port.last = (st.cnt >= n_eff - pclk_pkg::DIV_ONE);
    nx = st;
    if (port.restart || port.last) begin
      nx.cnt = 4'h0;
    end else begin
      nx.cnt = st.cnt + 4'h1;
    end
    // high phase first, so a fresh period never begins with a low runt
    port.level_next = (nx.cnt < high_len);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{cnt: 4'h0};
    end else begin
      st <= nx;
    end
  end

  a_div_range: assert property (@(posedge clk) disable iff (!rst_n)
    (port.divisor == $past(port.divisor)) |-> (st.cnt < n_eff))
    else $error("divider count beyond divisor");

  a_div_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (port.last || port.restart) |=> (st.cnt == 4'h0))
    else $error("divider did not wrap at period end");

endmodule

`default_nettype wire

// ==== pclk_adapt_out.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - second source is master clock over its 4-bit divisor, default 5, zero as one
// - adaptive: first source moves to second at half buffer fullness
// - third source is master clock over its 4-bit divisor, default 3, zero as one
// - adaptive: second source moves to third at three quarters fullness
// - pad slew follows the 3-bit slew field of the selected source
// - each spoof line carries exactly the programmed width in bytes, default 1600
// - switching only with variable clock enable set, else first source
// - third back to second below half, second to first below quarter
// - every frame starts on the first source
// - first source is master clock over its 4-bit divisor, default 1, zero as one
module pclk_adapt_out (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [10:0] fifo_fill,
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic [7:0] byte_in,
  output logic byte_take,
  output logic [7:0] byte_out,
  output logic line_valid,
  output logic pixel_out_clock,
  output logic [2:0] pixel_out_slew
);
  typedef struct packed {
    pclk_pkg::src_t sel;
    logic frame_pend;
    logic pclk;
    logic [2:0] slew;
    logic line_active;
    logic [11:0] count;
    logic [11:0] line_width;
    logic [7:0] data;
    logic take;
    logic var_en;
    logic [15:0] cfg_ab;
    logic [7:0] cfg_c;
    logic [11:0] width;
    logic [15:0] rdata;
  } state_t;

  state_t st;
  state_t nx;
  pclk_pkg::src_t tgt;
  logic cur_last;
  logic [2:0] restart;
  logic [2:0] slew_a;
  logic [2:0] slew_b;
  logic [2:0] slew_c;

  // ----------------------------------------------------------------
  // source dividers
  // ----------------------------------------------------------------
  div_if div_a ();
  div_if div_b ();
  div_if div_c ();

  assign div_a.divisor = st.cfg_ab[pclk_pkg::DIV_A_LSB +: pclk_pkg::DIV_W];
  assign div_b.divisor = st.cfg_ab[pclk_pkg::DIV_B_LSB +: pclk_pkg::DIV_W];
  assign div_c.divisor = st.cfg_c[pclk_pkg::DIV_C_LSB +: pclk_pkg::DIV_W];
  assign div_a.restart = restart[0];
  assign div_b.restart = restart[1];
  assign div_c.restart = restart[2];

  pclk_divider u_div_a (
    .clk(clk),
    .rst_n(rst_n),
    .port(div_a.gen)
  );

  pclk_divider u_div_b (
    .clk(clk),
    .rst_n(rst_n),
    .port(div_b.gen)
  );

  pclk_divider u_div_c (
    .clk(clk),
    .rst_n(rst_n),
    .port(div_c.gen)
  );

  assign slew_a = st.cfg_ab[pclk_pkg::SLEW_A_LSB +: pclk_pkg::SLEW_W];
  assign slew_b = st.cfg_ab[pclk_pkg::SLEW_B_LSB +: pclk_pkg::SLEW_W];
  assign slew_c = st.cfg_c[pclk_pkg::SLEW_C_LSB +: pclk_pkg::SLEW_W];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nx = st;
    nx.take = 1'b0;
    nx.rdata = 16'h0000;
    case (st.sel)
      pclk_pkg::SRC_A: cur_last = div_a.last;
      pclk_pkg::SRC_B: cur_last = div_b.last;
      pclk_pkg::SRC_C: cur_last = div_c.last;
      default: cur_last = 1'b1;
    endcase

    // fullness driven target
    tgt = st.sel;
    case (st.sel)
      pclk_pkg::SRC_A: begin
        if (st.var_en && fifo_fill >= pclk_pkg::FILL_HALF) begin
          tgt = pclk_pkg::SRC_B;
        end
      end
      pclk_pkg::SRC_B: begin
        if (!st.var_en) begin
          tgt = pclk_pkg::SRC_A;
        end else if (fifo_fill >= pclk_pkg::FILL_THREEQ) begin
          tgt = pclk_pkg::SRC_C;
        end else if (fifo_fill < pclk_pkg::FILL_QUARTER) begin
          tgt = pclk_pkg::SRC_A;
        end
      end
      pclk_pkg::SRC_C: begin
        if (!st.var_en) begin
          tgt = pclk_pkg::SRC_A;
        end else if (fifo_fill < pclk_pkg::FILL_HALF) begin
          tgt = pclk_pkg::SRC_B;
        end
      end
      default: tgt = pclk_pkg::SRC_A;
    endcase
    if (st.frame_pend || frame_start) begin
      tgt = pclk_pkg::SRC_A;
    end

    // swap only when the running period ends; new source starts fresh
    restart = 3'h0;
    if (cur_last) begin
      nx.frame_pend = 1'b0;
      nx.sel = tgt;
      if (tgt != st.sel) begin
        restart = tgt;
      end
    end else if (frame_start) begin
      nx.frame_pend = 1'b1;
    end

    case (nx.sel)
      pclk_pkg::SRC_A: nx.pclk = div_a.level_next;
      pclk_pkg::SRC_B: nx.pclk = div_b.level_next;
      pclk_pkg::SRC_C: nx.pclk = div_c.level_next;
      default: nx.pclk = 1'b0;
    endcase
    case (nx.sel)
      pclk_pkg::SRC_A: nx.slew = slew_a;
      pclk_pkg::SRC_B: nx.slew = slew_b;
      pclk_pkg::SRC_C: nx.slew = slew_c;
      default: nx.slew = slew_a;
    endcase

    // spoof line: width latched so a mid-line write cannot stretch it
    if (!st.line_active) begin
      if (line_start && st.width != 12'h000 && !st.frame_pend) begin
        nx.line_active = 1'b1;
        nx.count = 12'h000;
        nx.line_width = st.width;
      end
    end else if (cur_last) begin
      if (st.count >= st.line_width) begin
        nx.line_active = 1'b0;
      end else begin
        nx.data = byte_in;
        nx.take = 1'b1;
        nx.count = st.count + 12'h001;
      end
    end

    // register port
    if (reg_wr) begin
      case (reg_addr)
        pclk_pkg::ADDR_CTRL: nx.var_en = reg_wdata[pclk_pkg::VAR_EN_BIT];
        pclk_pkg::ADDR_CFG_AB: nx.cfg_ab = reg_wdata & pclk_pkg::CFG_AB_MASK;
        pclk_pkg::ADDR_CFG_C: nx.cfg_c = reg_wdata[7:0] & pclk_pkg::CFG_C_MASK;
        pclk_pkg::ADDR_WIDTH: nx.width = reg_wdata[pclk_pkg::WIDTH_W-1:0];
        default: nx.var_en = st.var_en;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        pclk_pkg::ADDR_CTRL: nx.rdata = 16'(st.var_en) << pclk_pkg::VAR_EN_BIT;
        pclk_pkg::ADDR_CFG_AB: nx.rdata = st.cfg_ab;
        pclk_pkg::ADDR_CFG_C: nx.rdata = {8'h00, st.cfg_c};
        pclk_pkg::ADDR_WIDTH: nx.rdata = {4'h0, st.width};
        pclk_pkg::ADDR_STATUS: nx.rdata = {11'h000, st.frame_pend, st.line_active, st.sel};
        default: nx.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{
        sel: pclk_pkg::SRC_A,
        frame_pend: 1'b0,
        pclk: 1'b1,
        slew: 3'h0,
        line_active: 1'b0,
        count: 12'h000,
        line_width: 12'h000,
        data: 8'h00,
        take: 1'b0,
        var_en: 1'b0,
        cfg_ab: pclk_pkg::CFG_AB_RESET,
        cfg_c: pclk_pkg::CFG_C_RESET,
        width: pclk_pkg::WIDTH_RESET,
        rdata: 16'h0000
      };
    end else begin
      st <= nx;
    end
  end

  assign reg_rdata = st.rdata;
  assign byte_take = st.take;
  assign byte_out = st.data;
  assign line_valid = st.line_active;
  assign pixel_out_clock = st.pclk;
  assign pixel_out_slew = st.slew;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_up_to_b: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_A && st.var_en && fifo_fill >= pclk_pkg::FILL_HALF
     && cur_last && !st.frame_pend && !frame_start) |=> (st.sel == pclk_pkg::SRC_B))
    else $error("no move to second source at half fullness");

  a_up_to_c: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_B && st.var_en && fifo_fill >= pclk_pkg::FILL_THREEQ
     && cur_last && !st.frame_pend && !frame_start) |=> (st.sel == pclk_pkg::SRC_C))
    else $error("no move to third source at three quarters");

  a_down_to_b: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_C && st.var_en && fifo_fill < pclk_pkg::FILL_HALF
     && cur_last && !st.frame_pend && !frame_start) |=> (st.sel == pclk_pkg::SRC_B))
    else $error("no step back from third source");

  a_down_to_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_B && st.var_en && fifo_fill < pclk_pkg::FILL_QUARTER
     && cur_last) |=> (st.sel == pclk_pkg::SRC_A))
    else $error("no step back to first source");

  a_hold_first: assert property (@(posedge clk) disable iff (!rst_n)
    (!st.var_en && st.sel == pclk_pkg::SRC_A) |=> (st.sel == pclk_pkg::SRC_A))
    else $error("source left first with adaptive off");

  a_frame_first: assert property (@(posedge clk) disable iff (!rst_n)
    frame_start |-> ##[1:16] (st.sel == pclk_pkg::SRC_A && !st.frame_pend))
    else $error("frame did not start on first source");

  a_switch_edge: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(st.sel) |-> ($past(cur_last) && st.pclk))
    else $error("source changed inside a period");

  a_slew_track: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_C) |-> (st.slew == $past(slew_c)))
    else $error("pad slew does not follow third source");

  a_line_bytes: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(st.line_active) |-> ($past(st.count) == $past(st.line_width)))
    else $error("line ended with wrong byte count");

  a_take_in_line: assert property (@(posedge clk) disable iff (!rst_n)
    st.take |-> (st.line_active && st.count != 12'h000))
    else $error("byte sent outside a line");

  a_slew_first: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_A) |-> (st.slew == $past(slew_a)))
    else $error("pad slew does not follow first source");

  a_slew_second: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sel == pclk_pkg::SRC_B) |-> (st.slew == $past(slew_b)))
    else $error("pad slew does not follow second source");

  a_drop_to_first: assert property (@(posedge clk) disable iff (!rst_n)
    (!st.var_en && cur_last) |=> (st.sel == pclk_pkg::SRC_A))
    else $error("adaptive off did not return to first source");

  a_fresh_period: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_last && tgt != st.sel) |=> st.pclk)
    else $error("new source did not open with a high phase");

endmodule

`default_nettype wire

// ==== host_line_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// receiving host: counts bytes of each spoof line
// ----------------------------------------------------------------
module host_line_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_valid,
  input wire logic byte_take,
  input wire logic [7:0] byte_out,
  output logic [11:0] line_bytes,
  output logic [7:0] first_byte,
  output logic [7:0] last_byte
);
  logic lv_d;
  // count restarts at each line-valid rise, a take in that cycle counts
  always_ff @(posedge clk) begin
    lv_d <= line_valid;
    if (!rst_n) begin
      line_bytes <= 12'h000;
      first_byte <= 8'h00;
      last_byte <= 8'h00;
    end else if (byte_take) begin
      line_bytes <= (line_valid && !lv_d) ? 12'h001 : line_bytes + 12'h001;
      if (line_bytes == 12'h000 || (line_valid && !lv_d)) begin
        first_byte <= byte_out;
      end
      last_byte <= byte_out;
    end else if (line_valid && !lv_d) begin
      line_bytes <= 12'h000;
    end
  end
endmodule

`default_nettype wire

// ==== adaptive_output_clock_spoof_width_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module adaptive_output_clock_spoof_width_test;
  logic clk, rst_n, reg_wr, reg_rd, frame_start, line_start;
  logic byte_take, line_valid, pixel_out_clock;
  logic [7:0] reg_addr, byte_out, first_byte, last_byte;
  logic [7:0] byte_in;
  logic [7:0] popped = 8'h00;
  logic [15:0] reg_wdata, reg_rdata, d, n;
  logic [10:0] fifo_fill;
  logic [2:0] pixel_out_slew;
  logic [11:0] line_bytes;
  int bad_count = 0;
  int n_compared = 0;

  pclk_adapt_out dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fifo_fill(fifo_fill), .frame_start(frame_start), .line_start(line_start),
    .byte_in(byte_in), .byte_take(byte_take), .byte_out(byte_out),
    .line_valid(line_valid), .pixel_out_clock(pixel_out_clock),
    .pixel_out_slew(pixel_out_slew));
  host_line_sink sink_u (.clk(clk), .rst_n(rst_n), .line_valid(line_valid),
    .byte_take(byte_take), .byte_out(byte_out), .line_bytes(line_bytes),
    .first_byte(first_byte), .last_byte(last_byte));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // buffer side: the take flag trails the consuming edge, so it counts in at once
  always @(posedge clk) if (byte_take === 1'b1) popped <= popped + 8'h01;
  assign byte_in = 8'h10 + popped + {7'h00, byte_take === 1'b1};

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask
  // polls status; a source change waits for a period end
  task automatic wait_sel(input string nm, input logic [2:0] e);
    for (int i = 0; i < 40; i++) begin
      rd(pclk_pkg::ADDR_STATUS, d);
      if (d[2:0] === e) break;
    end
    chk(nm, {13'h0000, e}, {13'h0000, d[2:0]});
  endtask
  // 30 cycles span whole periods of 1, 3 and 5
  task automatic hi(output logic [15:0] c);
    c = 16'h0000;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (pixel_out_clock === 1'b1) c = c + 16'h0001;
    end
  endtask
  task automatic line(input logic [15:0] w);
    @(posedge clk);
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      if (line_valid !== 1'b1) break;
    end
    repeat (2) @(posedge clk);
    chk("line bytes", w, {4'h0, line_bytes});
    // byte values wrap at 8 bits, so only the low byte of the span is known
    chk("byte order", (w - 16'h0001) & 16'h00ff, {8'h00, last_byte - first_byte});
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #2000000;
    bad_count++;
    $display("watchdog expired");
    results;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fifo_fill = 11'h000;
    frame_start = 1'b0;
    line_start = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl", pclk_pkg::ADDR_CTRL, 16'h0000);
    rdc("cfg ab", pclk_pkg::ADDR_CFG_AB, 16'h0501);
    rdc("cfg c", pclk_pkg::ADDR_CFG_C, 16'h0003);
    rdc("width", pclk_pkg::ADDR_WIDTH, 16'h0640);
    rdc("status", pclk_pkg::ADDR_STATUS, 16'h0001);
    rdc("unmapped", 8'h55, 16'h0000);
    $display("test registers done");
    line(16'h0640);
    wr(pclk_pkg::ADDR_WIDTH, 16'h0004);
    line(16'h0004);
    $display("test spoof lines done");
    wr(pclk_pkg::ADDR_CFG_AB, 16'hb541);
    rdc("cfg ab mask", pclk_pkg::ADDR_CFG_AB, 16'ha541);
    wr(pclk_pkg::ADDR_CFG_C, 16'h00d3);
    rdc("cfg c mask", pclk_pkg::ADDR_CFG_C, 16'h00c3);
    fifo_fill <= 11'd900;
    wait_sel("var off", 3'h1);
    wr(pclk_pkg::ADDR_CTRL, 16'h0040);
    fifo_fill <= 11'd512;
    wait_sel("to b", 3'h2);
    chk("slew b", 16'h0005, {13'h0000, pixel_out_slew});
    hi(n);
    chk("period b", 16'd18, n);
    fifo_fill <= 11'd768;
    wait_sel("to c", 3'h4);
    chk("slew c", 16'h0006, {13'h0000, pixel_out_slew});
    hi(n);
    chk("period c", 16'd20, n);
    fifo_fill <= 11'd511;
    wait_sel("c to b", 3'h2);
    fifo_fill <= 11'd255;
    wait_sel("b to a", 3'h1);
    chk("slew a", 16'h0002, {13'h0000, pixel_out_slew});
    $display("test adaptive done");
    wr(pclk_pkg::ADDR_CFG_AB, 16'ha040);
    hi(n);
    chk("zero div a", 16'd30, n);
    fifo_fill <= 11'd512;
    wait_sel("zero to b", 3'h2);
    hi(n);
    chk("zero div b", 16'd30, n);
    wr(pclk_pkg::ADDR_CTRL, 16'h0000);
    wait_sel("disable", 3'h1);
    $display("test zero divisor done");
    wr(pclk_pkg::ADDR_CFG_AB, 16'ha541);
    wr(pclk_pkg::ADDR_CTRL, 16'h0040);
    fifo_fill <= 11'd768;
    wait_sel("frame prep", 3'h4);
    @(posedge clk);
    frame_start <= 1'b1;
    fifo_fill <= 11'd000;
    @(posedge clk);
    frame_start <= 1'b0;
    // natural c to b to a would still show slew b here
    repeat (3) @(posedge clk);
    #1;
    chk("frame slew", 16'h0002, {13'h0000, pixel_out_slew});
    $display("test frame start done");
    results;
  end
endmodule

`default_nettype wire
